// *** charger_control_sequencer.sv ***
// Charge cycle sequencer with pin decode and APB register slave
// Overview of operation
// - Charge cycle runs alone when allowed
// - Phases: precondition, constant current, constant voltage
// - In CV, end below termination current
// - After done, restart below recharge threshold
// - Input limit hit in precondition, CC or CV: zero charge, supplement
// - Source select works only when enabled
// - Select high forces 500 mA limit
// - Select low uses register limit field
// - Power good low inside valid input window
// - Status released high when charging disabled
// - Interrupt pulse on supply and status events
// - Charging only while enable pin low
// - Enable pin high stops charge and regulation
// - Button low 430 ms exits ship mode
// - No input, 10 s hold: reset switch
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module charger_control_sequencer
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        source_select,
  input  wire logic        charge_enable_n,
  input  wire logic        button_n,
  // Analog comparator levels
  input  wire logic        vin_above_uvlo,
  input  wire logic        vin_below_ovp,
  input  wire logic        vin_above_sleep,
  input  wire logic        vbat_above_precond,
  input  wire logic        vbat_at_regulation,
  input  wire logic        ichg_below_term,
  input  wire logic        vbat_below_recharge,
  input  wire logic        input_limit_hit,
  input  wire logic        fault,
  // Outputs
  output logic             power_good_n_o,
  output logic             power_good_n_oe,
  output logic             charge_status_o,
  output logic             charge_status_oe,
  output logic             irq_pulse_n_o,
  output logic             irq_pulse_n_oe,
  output logic             charge_on,
  output logic             supplement_on,
  output logic             sys_reg_on,
  output logic             battery_switch,
  output logic [4:0]       input_limit,
  output logic [2:0]       phase_out,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  wire  [NSYNC-1:0] raw_in = {source_select, charge_enable_n, button_n, vin_above_uvlo, vin_below_ovp,
                              vin_above_sleep, vbat_above_precond, vbat_at_regulation, ichg_below_term,
                              vbat_below_recharge, input_limit_hit, fault};

  // Two flip-flops per outside level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else if (ce)
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  wire s_src_sel   = sync2[11];
  wire s_ce_n      = sync2[10];
  wire s_button_n  = sync2[9];
  wire s_uvlo_ok   = sync2[8];
  wire s_ovp_ok    = sync2[7];
  wire s_sleep_ok  = sync2[6];
  wire s_precond   = sync2[5];
  wire s_at_reg    = sync2[4];
  wire s_term      = sync2[3];
  wire s_recharge  = sync2[2];
  wire s_limit_hit = sync2[1];
  wire s_fault     = sync2[0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0]                      limit_field;
  logic                            src_en;
  logic                            term_en;
  logic [charger_pkg::IRQ_W-1:0]   irq_status;
  logic [charger_pkg::IRQ_W-1:0]   irq_mask;
  charger_pkg::phase_t             phase;
  charger_pkg::phase_t             next_phase;

  // Bus decode
  wire apb_acc    = psel && penable;
  wire apb_wr     = apb_acc && pwrite;
  wire hit_ctrl   = paddr == charger_pkg::ADDR_CTRL;
  wire hit_status = paddr == charger_pkg::ADDR_STATUS;
  wire hit_irq    = paddr == charger_pkg::ADDR_IRQ;
  wire hit_mask   = paddr == charger_pkg::ADDR_MASK;
  wire hit_any    = hit_ctrl || hit_status || hit_irq || hit_mask;
  wire [charger_pkg::IRQ_W-1:0] irq_clear = (apb_wr && pready && hit_irq) ? pwdata[charger_pkg::IRQ_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Input supply and enable decode
  // ----------------------------------------------------------------
  // valid input window
  wire input_good  = s_uvlo_ok && s_ovp_ok && s_sleep_ok;
  wire charge_ok   = !s_ce_n;

  wire src_active  = src_en;
  wire [4:0] next_limit = (src_active && s_src_sel) ? charger_pkg::LIMIT_500MA : limit_field;

  // ----------------------------------------------------------------
  // Charge phase sequencing
  // ----------------------------------------------------------------
  // autonomous cycle
  always_comb
  begin
    next_phase = phase;
    if (!charge_ok || !input_good)
      next_phase = charger_pkg::PH_IDLE;
    else
    begin
      case (phase)
        charger_pkg::PH_IDLE:
          next_phase = charger_pkg::PH_PRECOND;
        charger_pkg::PH_PRECOND:
          if (s_limit_hit)
            next_phase = charger_pkg::PH_SUPPLEMENT;
          else if (s_precond)
            next_phase = charger_pkg::PH_CC;
        charger_pkg::PH_CC:
          if (s_limit_hit)
            next_phase = charger_pkg::PH_SUPPLEMENT;
          else if (s_at_reg)
            next_phase = charger_pkg::PH_CV;
        charger_pkg::PH_CV:
          if (s_limit_hit)
            next_phase = charger_pkg::PH_SUPPLEMENT;
          else if (term_en && s_term)
            next_phase = charger_pkg::PH_DONE;
        charger_pkg::PH_DONE:
          if (s_recharge)
            next_phase = charger_pkg::PH_PRECOND;
        charger_pkg::PH_SUPPLEMENT:
          if (!s_limit_hit)
            next_phase = charger_pkg::PH_PRECOND;
        default:
          next_phase = charger_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase <= charger_pkg::PH_IDLE;
    else if (ce)
      phase <= next_phase;
  end

  // ----------------------------------------------------------------
  // Millisecond tick and push-button
  // ----------------------------------------------------------------
  logic [14:0] tick_cnt;
  logic        tick;
  wire  tick_wrap = tick_cnt == 15'(charger_pkg::TICK_CYCLES - 1);

  // Divides pclk to 1 ms
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else if (ce)
    begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
      tick     <= tick_wrap;
    end
  end

  logic [charger_pkg::MS_W-1:0] held_ms;

  button_timer u_button_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (tick),
    .pressed (!s_button_n),
    .held_ms (held_ms)
  );

  charger_pkg::btn_state_t        btn_state;
  logic [charger_pkg::MS_W-1:0]   off_ms;
  wire ship_exit  = held_ms == charger_pkg::MS_W'(charger_pkg::SHIP_EXIT_MS);
  wire full_reset = !input_good && held_ms == charger_pkg::MS_W'(charger_pkg::FULL_RESET_MS);

  // Battery switch control: ship exit and full reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_state      <= charger_pkg::BTN_WAIT;
      off_ms         <= '0;
      battery_switch <= 1'b1;
    end
    else if (ce)
    begin
      case (btn_state)
        charger_pkg::BTN_WAIT:
          if (full_reset)
          begin
            battery_switch <= 1'b0;
            off_ms         <= '0;
            btn_state      <= charger_pkg::BTN_OFF;
          end
          else if (ship_exit)
            battery_switch <= 1'b1;
        charger_pkg::BTN_OFF:
          if (off_ms == charger_pkg::MS_W'(charger_pkg::SWITCH_OFF_MS))
          begin
            battery_switch <= 1'b1;
            btn_state      <= charger_pkg::BTN_HOLD;
          end
          else if (tick)
            off_ms <= off_ms + 1'b1;
        charger_pkg::BTN_HOLD:
          if (held_ms == '0)
            btn_state <= charger_pkg::BTN_WAIT;
        default:
          btn_state <= charger_pkg::BTN_WAIT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events and pulse
  // ----------------------------------------------------------------
  logic input_good_d;
  logic fault_d;
  wire [charger_pkg::IRQ_W-1:0] irq_set = {s_fault && !fault_d, phase != next_phase,
                                           input_good_d && !input_good, !input_good_d && input_good};
  logic [3:0] pulse_cnt;

  // sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_good_d <= 1'b0;
      fault_d      <= 1'b0;
      irq_status   <= '0;
      pulse_cnt    <= '0;
    end
    else if (ce)
    begin
      input_good_d <= input_good;
      fault_d      <= s_fault;
      irq_status   <= (irq_status & ~irq_clear) | irq_set;
      if (|irq_set)
        pulse_cnt <= 4'(charger_pkg::IRQ_PULSE_CYCLES);
      else if (pulse_cnt != '0)
        pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    hit_ctrl   ? {25'h0, term_en, src_en, limit_field} :
    hit_status ? {26'h0, s_ce_n, input_good, battery_switch, phase} :
    hit_irq    ? {28'h0, irq_status} :
    hit_mask   ? {28'h0, irq_mask} : 32'h0;

  // Writes, read data and single-wait answers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      limit_field <= charger_pkg::LIMIT_RESET;
      src_en      <= charger_pkg::SRC_EN_RESET;
      term_en     <= charger_pkg::TERM_EN_RESET;
      irq_mask    <= charger_pkg::MASK_RESET;
      prdata      <= '0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel && !pready && penable;
      pslverr <= psel && penable && !pready && !hit_any;
      if (psel && penable && !pready)
        prdata <= pwrite ? 32'h0 : rd_mux;
      if (apb_wr && pready && hit_ctrl)
      begin
        limit_field <= pwdata[charger_pkg::CTRL_LIMIT_LSB +: 5];
        src_en      <= pwdata[charger_pkg::CTRL_SRC_EN_BIT];
        term_en     <= pwdata[charger_pkg::CTRL_TERM_EN_BIT];
      end
      if (apb_wr && pready && hit_mask)
        irq_mask <= pwdata[charger_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_good_n_oe  <= 1'b0;
      charge_status_oe <= 1'b0;
      irq_pulse_n_oe   <= 1'b0;
      charge_on        <= 1'b0;
      supplement_on    <= 1'b0;
      sys_reg_on       <= 1'b0;
      input_limit      <= charger_pkg::LIMIT_RESET;
      phase_out        <= '0;
      irq              <= 1'b0;
    end
    else if (ce)
    begin
      power_good_n_oe  <= input_good;
      charge_status_oe <= charge_ok && (phase == charger_pkg::PH_PRECOND || phase == charger_pkg::PH_CC ||
                                        phase == charger_pkg::PH_CV);
      irq_pulse_n_oe   <= pulse_cnt != '0;
      charge_on        <= charge_ok && (phase == charger_pkg::PH_PRECOND || phase == charger_pkg::PH_CC ||
                                        phase == charger_pkg::PH_CV);
      supplement_on    <= phase == charger_pkg::PH_SUPPLEMENT;
      sys_reg_on       <= charge_ok;
      input_limit      <= next_limit;
      phase_out        <= phase;
      irq              <= |(irq_status & irq_mask);
    end
  end

  // Open-drain data lines always low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_good_n_o  <= 1'b0;
      charge_status_o <= 1'b0;
      irq_pulse_n_o   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SUPP_NO_CHARGE: assert property (@(posedge pclk) disable iff (!presetn)
    supplement_on |-> !charge_on) else $error("Charge on during supplement");
  AST_CE_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && s_ce_n |=> !charge_on && !sys_reg_on) else $error("Enable pin high but charging");
  AST_PG: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> power_good_n_oe == $past(input_good)) else $error("Power good mismatch");
  AST_STAT_REL: assert property (@(posedge pclk) disable iff (!presetn)
    ce && s_ce_n |=> !charge_status_oe) else $error("Status driven while disabled");
  AST_LIMIT_500: assert property (@(posedge pclk) disable iff (!presetn)
    ce && src_en && s_src_sel |=> input_limit == charger_pkg::LIMIT_500MA) else $error("500 mA not forced");
  AST_LIMIT_REG: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(src_en && s_src_sel) |=> input_limit == $past(limit_field)) else $error("Limit field not used");
  AST_CV_TERM: assert property (@(posedge pclk) disable iff (!presetn)
    ce && phase == charger_pkg::PH_CV && charge_ok && input_good && !s_limit_hit && term_en && s_term
    |=> phase == charger_pkg::PH_DONE) else $error("No termination in CV");
  AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    ce && phase == charger_pkg::PH_PRECOND |=> phase inside {charger_pkg::PH_PRECOND, charger_pkg::PH_CC,
    charger_pkg::PH_SUPPLEMENT, charger_pkg::PH_IDLE}) else $error("Phase skipped");
  AST_IRQ_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (|irq_set) |=> ce [*1] ##1 irq_pulse_n_oe) else $error("No interrupt pulse");

endmodule // charger_control_sequencer

// *** charger_pkg.sv ***
// Package with constants and types for the charger control sequencer
package charger_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ    = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_LIMIT_LSB  = 0;   // input_limit_field [4:0]
  localparam int         CTRL_SRC_EN_BIT = 5;   // source-select enable
  localparam int         CTRL_TERM_EN_BIT = 6;  // termination enable
  localparam logic [4:0] LIMIT_RESET     = 5'h08;
  localparam logic [4:0] LIMIT_500MA     = 5'h04; // Code of the fixed 500 mA limit
  localparam logic       SRC_EN_RESET    = 1'b0;
  localparam logic       TERM_EN_RESET   = 1'b1;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_W         = 4;
  localparam int IRQ_SRC_IN    = 0;  // Input supply inserted
  localparam int IRQ_SRC_OUT   = 1;  // Input supply removed
  localparam int IRQ_PHASE     = 2;  // Charge phase changed
  localparam int IRQ_FAULT     = 3;  // Fault seen
  localparam logic [IRQ_W-1:0] MASK_RESET = 4'hf;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20000000;
  localparam int TICK_MS         = 1;
  localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int SHIP_EXIT_MS    = 430;
  localparam int FULL_RESET_S    = 10;
  localparam int FULL_RESET_MS   = FULL_RESET_S * 1000;
  localparam int SWITCH_OFF_MS   = 430;
  localparam int IRQ_PULSE_CYCLES = 8;
  localparam int MS_W            = 14;

  // ----------------------------------------------------------------
  // Charge phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_PRECOND, PH_CC, PH_CV, PH_DONE, PH_SUPPLEMENT
  } phase_t;

  typedef enum logic [1:0] {
    BTN_WAIT, BTN_OFF, BTN_HOLD
  } btn_state_t;

endpackage

// *** button_timer.sv ***
// Push-button hold timer clocked by a millisecond tick
`timescale 1ns/1ps
module button_timer
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       ce,
  input  wire logic                       tick,
  input  wire logic                       pressed,
  output logic [charger_pkg::MS_W-1:0]    held_ms
);

  // ----------------------------------------------------------------
  // Hold counter
  // ----------------------------------------------------------------
  // restart on release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      held_ms <= '0;
    else if (ce)
    begin
      if (!pressed)
        held_ms <= '0;
      else if (tick && held_ms != {charger_pkg::MS_W{1'b1}})
        held_ms <= held_ms + 1'b1;
    end
  end

endmodule // button_timer

// *** charger_partner.sv ***
// Far-side model: host pins with pull-ups, input source comparators and a battery
`timescale 1ns/1ps
module charger_partner
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       allow,
  input  wire logic       slow,
  input  wire logic       drain,
  input  wire logic [2:0] vin_lvl,
  input  wire logic       charge_on,
  input  wire logic       power_good_n_oe,
  input  wire logic       charge_status_oe,
  input  wire logic       irq_pulse_n_oe,
  output logic            charge_enable_n,
  output logic            vin_above_uvlo,
  output logic            vin_below_ovp,
  output logic            vin_above_sleep,
  output logic            vbat_above_precond,
  output logic            vbat_at_regulation,
  output logic            ichg_below_term,
  output logic            vbat_below_recharge,
  output logic            power_good_pin,
  output logic            charge_status_pin,
  output logic            irq_pin
);
  logic [7:0] level;
  logic [1:0] div;
  logic [5:0] taper;

  // host pulls enable low to permit charging
  assign charge_enable_n = ~allow;
  // Input source window levels, one per comparator
  assign {vin_above_sleep, vin_below_ovp, vin_above_uvlo} = vin_lvl;
  // Pull-ups on the open-drain lines
  assign power_good_pin    = power_good_n_oe ? 1'b0 : 1'b1;
  assign charge_status_pin = charge_status_oe ? 1'b0 : 1'b1;
  assign irq_pin           = irq_pulse_n_oe ? 1'b0 : 1'b1;
  // Battery thresholds; current tapers once at regulation
  assign vbat_above_precond  = level >= 8'h14;
  assign vbat_at_regulation  = level >= 8'h3c;
  assign ichg_below_term     = taper >= 6'h1e;
  assign vbat_below_recharge = level < 8'h37;

  // --------------------------------------------------------------
  // Battery charge state, slow mode rises one step per four cycles
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      level <= 8'h00;
      div   <= 2'h0;
      taper <= 6'h00;
    end
    else
    begin
      div <= div + 2'h1;
      if (drain && level != 8'h00)
        level <= level - 8'h01;
      else if (charge_on && level < 8'h3c && (!slow || div == 2'h0))
        level <= level + 8'h01;
      taper <= (charge_on && level >= 8'h3c) ? ((taper == 6'h3f) ? taper : taper + 6'h01) : 6'h00;
    end
endmodule // charger_partner

// *** charger_control_sequencer_tb.sv ***
// Self-checking testbench of the charger control sequencer
`timescale 1ns/1ps
module charger_control_sequencer_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        source_select, charge_enable_n, button_n, vin_above_uvlo, vin_below_ovp, vin_above_sleep;
  logic        vbat_above_precond, vbat_at_regulation, ichg_below_term, vbat_below_recharge;
  logic        input_limit_hit, fault, power_good_n_o, power_good_n_oe, charge_status_o, charge_status_oe;
  logic        irq_pulse_n_o, irq_pulse_n_oe, charge_on, supplement_on, sys_reg_on, battery_switch, irq;
  logic        allow, slow, drain, track, power_good_pin, charge_status_pin, irq_pin;
  logic [2:0]  vin_lvl, phase_out, prev_ph;
  logic [4:0]  input_limit, fld;
  logic [64:0] exp_q[$];
  logic [2:0]  ph_q[$];
  int          fails, checks, n;

  charger_control_sequencer charger_control_sequencer_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .source_select, .charge_enable_n, .button_n, .vin_above_uvlo,
    .vin_below_ovp, .vin_above_sleep, .vbat_above_precond, .vbat_at_regulation, .ichg_below_term,
    .vbat_below_recharge, .input_limit_hit, .fault, .power_good_n_o, .power_good_n_oe, .charge_status_o,
    .charge_status_oe, .irq_pulse_n_o, .irq_pulse_n_oe, .charge_on, .supplement_on, .sys_reg_on,
    .battery_switch, .input_limit, .phase_out, .irq);
  charger_partner charger_partner_inst (.pclk, .presetn, .allow, .slow, .drain, .vin_lvl, .charge_on,
    .power_good_n_oe, .charge_status_oe, .irq_pulse_n_oe, .charge_enable_n, .vin_above_uvlo, .vin_below_ovp,
    .vin_above_sleep, .vbat_above_precond, .vbat_at_regulation, .ichg_below_term, .vbat_below_recharge,
    .power_good_pin, .charge_status_pin, .irq_pin);

  // --------------------------------------------------------------
  // Clock, checking and closing tasks
  // --------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; the expected answer is noted for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m, input logic er);
    int k;
    exp_q.push_back({er, m, e});
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  // Bounded wait on phase (sel 0) or charge activity (sel 1)
  task automatic wait_on(input int sel, input logic [2:0] v);
    int k;
    k = 0;
    while (k < 3000 && ((sel == 0) ? (phase_out !== v) : (charge_on !== v[0])))
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 3000)
    begin
      fails++;
      complete_run();
    end
  endtask

  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask

  // APB answers and phase steps taken off the queues
  always @(posedge pclk)
  begin
    if (pready === 1'b1)
    begin
      if (exp_q.size() == 0)
        exp_q.push_back({1'b0, 32'h0, 32'hdeadbeef});
      cmp(prdata & exp_q[0][63:32], exp_q[0][31:0]);
      cmp({31'h0, pslverr}, {31'h0, exp_q[0][64]});
      void'(exp_q.pop_front());
    end
    prev_ph <= phase_out;
    if (track && presetn && phase_out !== prev_ph)
      cmp({29'h0, phase_out}, {29'h0, (ph_q.size() != 0) ? ph_q.pop_front() : 3'h7});
  end

  initial
  begin
    repeat (90000) @(posedge pclk);
    fails++;
    complete_run();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, source_select, input_limit_hit, fault} = '0;
    {allow, drain, track, vin_lvl} = '0;
    {ce, slow, button_n} = 3'b111;
    fails = 0;
    checks = 0;
    r = $urandom(82);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp(battery_switch, 1'b1);
    cmp(input_limit, 5'h08);
    apb(1'b0, charger_pkg::ADDR_CTRL, 32'h0, 32'h48, 32'h7f, 1'b0);
    apb(1'b0, charger_pkg::ADDR_MASK, 32'h0, 32'hf, 32'hf, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    settle;
    cmp({sys_reg_on, charge_on, charge_status_pin}, 3'b001);
    cmp({power_good_n_o, charge_status_o, irq_pulse_n_o}, 3'b000);
    for (n = 0; n < 8; n++)
    begin
      vin_lvl <= n[2:0];
      settle;
      cmp(power_good_n_oe, &n[2:0]);
    end
    // Full cycle with an overload in constant current
    ph_q = '{3'h1, 3'h2, 3'h5, 3'h1, 3'h2, 3'h3, 3'h4};
    track <= 1'b1;
    allow <= 1'b1;
    wait_on(0, 3'h2);
    input_limit_hit <= 1'b1;
    wait_on(0, 3'h5);
    settle;
    cmp({supplement_on, charge_on}, 2'b10);
    input_limit_hit <= 1'b0;
    wait_on(0, 3'h4);
    settle;
    track <= 1'b0;
    cmp(ph_q.size(), 0);
    cmp({irq, charge_on}, 2'b10);
    apb(1'b0, charger_pkg::ADDR_IRQ, 32'h0, 32'h5, 32'hf, 1'b0);
    apb(1'b1, charger_pkg::ADDR_IRQ, 32'hf, 32'h0, 32'h0, 1'b0);
    settle;
    cmp(irq, 1'b0);
    // Source select decode
    r = $urandom;
    fld = {r[4:3], 1'b0, r[1:0]};
    source_select <= 1'b1;
    apb(1'b1, charger_pkg::ADDR_CTRL, {25'h0, 2'b10, fld}, 32'h0, 32'h0, 1'b0);
    settle;
    cmp(input_limit, fld);
    apb(1'b1, charger_pkg::ADDR_CTRL, {25'h0, 2'b11, fld}, 32'h0, 32'h0, 1'b0);
    settle;
    cmp(input_limit, charger_pkg::LIMIT_500MA);
    source_select <= 1'b0;
    settle;
    cmp(input_limit, fld);
    // Enable pin taken away and given back
    allow <= 1'b0;
    settle;
    cmp({charge_on, sys_reg_on, charge_status_oe}, 3'b000);
    allow <= 1'b1;
    settle;
    cmp(sys_reg_on, 1'b1);
    wait_on(0, 3'h4);
    // Battery sags after termination
    slow <= 1'b0;
    drain <= 1'b1;
    repeat (12) @(posedge pclk);
    drain <= 1'b0;
    wait_on(1, 3'h1);
    // Short press is ignored
    button_n <= 1'b0;
    repeat (200) @(posedge pclk);
    button_n <= 1'b1;
    settle;
    cmp(battery_switch, 1'b1);
    // Masked fault event still pulses the line
    apb(1'b1, charger_pkg::ADDR_MASK, 32'h0, 32'h0, 32'h0, 1'b0);
    fault <= 1'b1;
    n = 0;
    while (n < 10 && irq_pulse_n_oe !== 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
    cmp({irq_pulse_n_oe, irq_pin}, 2'b10);
    settle;
    cmp(irq, 1'b0);
    apb(1'b0, charger_pkg::ADDR_IRQ, 32'h0, 32'h8, 32'h8, 1'b0);
    apb(1'b1, charger_pkg::ADDR_MASK, 32'h8, 32'h0, 32'h0, 1'b0);
    settle;
    cmp(irq, 1'b1);
    fault <= 1'b0;
    apb(1'b1, charger_pkg::ADDR_IRQ, 32'h8, 32'h0, 32'h0, 1'b0);
    settle;
    cmp(irq, 1'b0);
    cmp(exp_q.size(), 0);
    complete_run();
  end
endmodule // charger_control_sequencer_tb
